// ---- design/general_timers.sv ----
// Three 16-bit timers, the second and third pairable, on AXI4-Lite
//
// Notes on behaviour
// - Timer counts only while timer_run is set
// - idle_halt stops timer during Idle mode
// - Gate accumulates internal clock; ignored when external
// - Prescaler divides by 1, 8, 64, 256
// - Timer A external clock optionally resynchronised
// - Timer A counts pin a edges or internal
// - Timers B, C count own pin edges
// - pair_32bit_mode joins timers B and C
// - Timer C control ignored in 32-bit mode
// - Pair uses B clock/gate, C event flag
// - count_reg_c upper, count_reg_b lower word
// - Period compare uses period_reg_c:period_reg_b
// - Timers B, C count synchronously only
// - Only timer C or pair triggers ADC
// - Unimplemented control bits read as zero
// - Timer A events on match, gate fall
`default_nettype none
module general_timers
    import gtimer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic idle_mode,
    input wire logic ext_clock_pin_a,
    input wire logic ext_clock_pin_b,
    input wire logic ext_clock_pin_c,
    input wire logic gate_pin_a,
    input wire logic gate_pin_b,
    input wire logic gate_pin_c,
    output logic event_a,
    output logic event_b,
    output logic event_c,
    output logic adc_trigger
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [15:0] ctrl_reg [NUM_TMR], ctrl_next [NUM_TMR];
    logic [15:0] count_reg [NUM_TMR], count_next [NUM_TMR];
    logic [15:0] period_reg [NUM_TMR], period_next [NUM_TMR];
    logic [2:0] event_reg, event_next, edge_ext, tick;
    logic [2:0] clk_s1, clk_s2, clk_s3, gate_s1, gate_s2;
    logic adc_reg, adc_next, clk_s4_a, gate_s3_a, gate_fall_a, pair, do_write;
    logic [31:0] count32, period32;
    tick_cfg_s cfg [NUM_TMR];
    logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic [15:0] wdata_reg, wdata_next;
    logic [1:0] wstrb_reg, wstrb_next, bresp_reg, bresp_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;

    // Merge the held write lanes into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old);
        logic [15:0] r;
        r = old;
        if (wstrb_reg[0])
            r[7:0] = wdata_reg[7:0];
        if (wstrb_reg[1])
            r[15:8] = wdata_reg[15:8];
        return r;
    endfunction

    // Next count of one 16-bit word with wrap on period match
    function automatic logic [15:0] step16(input logic [15:0] cnt,
                                           input logic [15:0] per);
        return (cnt == per) ? COUNT_RESET : cnt + COUNT_ONE;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; no reset, they refill while the timers are off
    always_ff @(posedge aclk)
    begin
        clk_s1 <= {ext_clock_pin_c, ext_clock_pin_b, ext_clock_pin_a};
        clk_s2 <= clk_s1;
        clk_s3 <= clk_s2;
        clk_s4_a <= clk_s3[TMR_A];
        gate_s1 <= {gate_pin_c, gate_pin_b, gate_pin_a};
        gate_s2 <= gate_s1;
        gate_s3_a <= gate_s2[TMR_A];
    end

    // Rising edges; timer A may add an alignment stage to its edge
    always_comb
    begin
        edge_ext = clk_s2 & ~clk_s3;
        if (ctrl_reg[TMR_A][BIT_SYNC])
            edge_ext[TMR_A] = clk_s3[TMR_A] & ~clk_s4_a;
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-timer configuration; timer C made inactive while paired
    always_comb
    begin
        pair = ctrl_reg[TMR_B][BIT_PAIR];
        cfg[TMR_A] = cfg_from_ctrl(ctrl_reg[TMR_A], idle_mode);
        cfg[TMR_B] = cfg_from_ctrl(ctrl_reg[TMR_B], idle_mode);
        cfg[TMR_C] = cfg_from_ctrl(ctrl_reg[TMR_C], idle_mode);
        if (pair)
            cfg[TMR_C].active = 1'b0;
        gate_fall_a = cfg[TMR_A].active & cfg[TMR_A].gate_en
            & ~cfg[TMR_A].ext_sel & gate_s3_a & ~gate_s2[TMR_A];
    end

    // One tick generator per timer
    for (genvar i = 0; i < NUM_TMR; i++)
    begin : g_tick
        timer_tick u_tick (
            .aclk(aclk),
            .aresetn(aresetn),
            .cfg(cfg[i]),
            .ext_edge(edge_ext[i]),
            .gate_level(gate_s2[i]),
            .tick(tick[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel; address and data accepted in either order
    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
    assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;

    always_comb
    begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_next = 1'b1;
            wdata_next = s_axi_wdata[15:0];
            wstrb_next = s_axi_wstrb[1:0]; // Upper lanes hold zeros only
        end
        if (do_write)
        begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (aw_addr_reg > OFS_PERIOD_C || aw_addr_reg[1:0] != 2'h0)
                ? RESP_SLVERR : RESP_OKAY;
        end
        else if (bvalid_reg && s_axi_bready)
            bvalid_next = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel; one read in flight
    assign s_axi_arready = ~rvalid_reg;

    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = 32'h0000_0000;
            case (s_axi_araddr)
                OFS_CTRL_A: rdata_next[15:0] = ctrl_reg[TMR_A];
                OFS_CTRL_B: rdata_next[15:0] = ctrl_reg[TMR_B];
                OFS_CTRL_C: rdata_next[15:0] = ctrl_reg[TMR_C];
                OFS_COUNT_A: rdata_next[15:0] = count_reg[TMR_A];
                OFS_COUNT_B: rdata_next[15:0] = count_reg[TMR_B];
                OFS_COUNT_C: rdata_next[15:0] = count_reg[TMR_C];
                OFS_PERIOD_A: rdata_next[15:0] = period_reg[TMR_A];
                OFS_PERIOD_B: rdata_next[15:0] = period_reg[TMR_B];
                OFS_PERIOD_C: rdata_next[15:0] = period_reg[TMR_C];
                default: rresp_next = RESP_SLVERR;
            endcase
        end
        else if (rvalid_reg && s_axi_rready)
            rvalid_next = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters, period registers and control words
    always_comb
    begin
        ctrl_next = ctrl_reg;
        period_next = period_reg;
        count_next = count_reg;
        event_next = 3'h0;
        count32 = {count_reg[TMR_C], count_reg[TMR_B]};
        period32 = {period_reg[TMR_C], period_reg[TMR_B]};
        // Timer A
        if (tick[TMR_A])
        begin
            count_next[TMR_A] = step16(count_reg[TMR_A], period_reg[TMR_A]);
            event_next[TMR_A] = (count_reg[TMR_A] == period_reg[TMR_A]);
        end
        if (gate_fall_a)
            event_next[TMR_A] = 1'b1;
        // Timers B and C, joined or apart
        if (pair)
        begin
            if (tick[TMR_B])
            begin
                if (count32 == period32)
                begin
                    count_next[TMR_B] = COUNT_RESET;
                    count_next[TMR_C] = COUNT_RESET;
                    event_next[TMR_C] = 1'b1;
                end
                else
                begin
                    {count_next[TMR_C], count_next[TMR_B]} = count32 + 32'h1;
                end
            end
        end
        else
        begin
            for (int t = TMR_B; t <= TMR_C; t++)
            begin
                if (tick[t])
                begin
                    count_next[t] = step16(count_reg[t], period_reg[t]);
                    event_next[t] = (count_reg[t] == period_reg[t]);
                end
            end
        end
        // Software writes override counting in the same cycle
        if (do_write)
        begin
            case (aw_addr_reg)
                OFS_CTRL_A: ctrl_next[TMR_A] = merge16(ctrl_reg[TMR_A])
                    & CTRL_MASK_A;
                OFS_CTRL_B: ctrl_next[TMR_B] = merge16(ctrl_reg[TMR_B])
                    & CTRL_MASK_B;
                OFS_CTRL_C: ctrl_next[TMR_C] = merge16(ctrl_reg[TMR_C])
                    & CTRL_MASK_C;
                OFS_COUNT_A: count_next[TMR_A] = merge16(count_reg[TMR_A]);
                OFS_COUNT_B: count_next[TMR_B] = merge16(count_reg[TMR_B]);
                OFS_COUNT_C: count_next[TMR_C] = merge16(count_reg[TMR_C]);
                OFS_PERIOD_A: period_next[TMR_A] = merge16(period_reg[TMR_A]);
                OFS_PERIOD_B: period_next[TMR_B] = merge16(period_reg[TMR_B]);
                OFS_PERIOD_C: period_next[TMR_C] = merge16(period_reg[TMR_C]);
                default: ;
            endcase
        end
        // Timer B alone never drives the converter trigger
        adc_next = event_next[TMR_C];
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int t = 0; t < NUM_TMR; t++)
            begin
                ctrl_reg[t] <= CTRL_RESET;
                count_reg[t] <= COUNT_RESET;
                period_reg[t] <= PERIOD_RESET;
            end
            event_reg <= 3'h0;
            adc_reg <= 1'b0;
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_held_reg <= 1'b0;
            wdata_reg <= 16'h0000;
            wstrb_reg <= 2'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            count_reg <= count_next;
            period_reg <= period_next;
            event_reg <= event_next;
            adc_reg <= adc_next;
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign event_a = event_reg[TMR_A];
    assign event_b = event_reg[TMR_B];
    assign event_c = event_reg[TMR_C];
    assign adc_trigger = adc_reg;

endmodule
`default_nettype wire

// ---- design/gtimer_pkg.sv ----
// Shared constants, field positions and carrier types for the timer block
`default_nettype none
package gtimer_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the AXI4-Lite bus
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_CTRL_C = 8'h08;
    localparam logic [7:0] OFS_COUNT_A = 8'h0C;
    localparam logic [7:0] OFS_COUNT_B = 8'h10;
    localparam logic [7:0] OFS_COUNT_C = 8'h14;
    localparam logic [7:0] OFS_PERIOD_A = 8'h18;
    localparam logic [7:0] OFS_PERIOD_B = 8'h1C;
    localparam logic [7:0] OFS_PERIOD_C = 8'h20;

    // Timer indices into the register arrays
    localparam int TMR_A = 0;
    localparam int TMR_B = 1;
    localparam int TMR_C = 2;
    localparam int NUM_TMR = 3;

    ////////////////////////////////////////////////////////////////////////
    // Control word field positions
    localparam int BIT_RUN = 15;
    localparam int BIT_IDLE_HALT = 13;
    localparam int BIT_GATE_EN = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_PAIR = 3;
    localparam int BIT_SYNC = 2;
    localparam int BIT_CLK_SRC = 1;

    // Implemented bits per control word; all others read as zero
    localparam logic [15:0] CTRL_MASK_A = 16'hA076;
    localparam logic [15:0] CTRL_MASK_B = 16'hA07A;
    localparam logic [15:0] CTRL_MASK_C = 16'hA072;

    // Reset values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler codes and terminal counts (ratio minus one)
    localparam logic [1:0] PS_CODE_1 = 2'h0;
    localparam logic [1:0] PS_CODE_8 = 2'h1;
    localparam logic [1:0] PS_CODE_64 = 2'h2;
    localparam logic [7:0] PS_LIM_1 = 8'h00;
    localparam logic [7:0] PS_LIM_8 = 8'h07;
    localparam logic [7:0] PS_LIM_64 = 8'h3F;
    localparam logic [7:0] PS_LIM_256 = 8'hFF;
    localparam logic [7:0] PS_STEP = 8'h01;
    localparam logic [7:0] PS_ZERO = 8'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Per-timer configuration as seen by the tick generator
    typedef struct packed {
        logic active;
        logic ext_sel;
        logic gate_en;
        logic [1:0] prescale;
    } tick_cfg_s;

    // Terminal count of the prescaler for a select code
    function automatic logic [7:0] ps_limit(input logic [1:0] code);
        logic [7:0] lim;
        case (code)
            PS_CODE_1: lim = PS_LIM_1;
            PS_CODE_8: lim = PS_LIM_8;
            PS_CODE_64: lim = PS_LIM_64;
            default: lim = PS_LIM_256;
        endcase
        return lim;
    endfunction

    // Decode a control word into tick configuration
    function automatic tick_cfg_s cfg_from_ctrl(input logic [15:0] w,
                                                input logic idle_mode);
        tick_cfg_s c;
        c.active = w[BIT_RUN] & ~(w[BIT_IDLE_HALT] & idle_mode);
        c.ext_sel = w[BIT_CLK_SRC];
        c.gate_en = w[BIT_GATE_EN];
        c.prescale = w[BIT_PS_HI:BIT_PS_LO];
        return c;
    endfunction

endpackage
`default_nettype wire

// ---- design/timer_tick.sv ----
// Clock source, gate and prescaler stage producing count ticks
`default_nettype none
module timer_tick
    import gtimer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire tick_cfg_s cfg,
    input wire logic ext_edge,
    input wire logic gate_level,
    output logic tick
);

    logic [7:0] ps_reg;
    logic [7:0] ps_next;
    logic src;

    // Source select; gate only applies to the internal clock
    always_comb
    begin
        src = cfg.ext_sel ? ext_edge : (cfg.gate_en ? gate_level : 1'b1);
        ps_next = ps_reg;
        tick = 1'b0;
        if (!cfg.active)
        begin
            ps_next = PS_ZERO; // Prescaler restarts cleanly on each run
        end
        else if (src)
        begin
            if (ps_reg >= ps_limit(cfg.prescale))
            begin
                ps_next = PS_ZERO;
                tick = 1'b1;
            end
            else
            begin
                ps_next = ps_reg + PS_STEP;
            end
        end
    end

    // Prescaler state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ps_reg <= PS_ZERO;
        else
            ps_reg <= ps_next;
    end

endmodule
`default_nettype wire

// ---- tb/general_timers_checker.sv ----
// Concurrent checks on the timer block's bus and event ports
`default_nettype none
module general_timers_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic event_c,
    input wire logic adc_trigger
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Both halves of a write taken at one edge
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    chk_write_answer:
        assert property (wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late");
    chk_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    // Answers stand until taken, so the master never misses one
    chk_bresp_hold:
        assert property (s_axi_bvalid && !s_axi_bready
            |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_rdata_hold:
        assert property (s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_b_clear:
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    chk_write_block:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    chk_read_block:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    chk_upper_zero:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    chk_adc_pair:
        assert property (adc_trigger == event_c)
        else $error("converter trigger apart from third event");
endmodule
bind general_timers general_timers_checker u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .event_c(event_c),
    .adc_trigger(adc_trigger));
`default_nettype wire

// ---- tb/gtimer_pins.sv ----
// Pin-side model: external count clocks and gate levels
`default_nettype none
module gtimer_pins (
    input wire logic aclk,
    output logic [2:0] pin,
    output logic [2:0] gate
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin = 3'h0;
    initial gate = 3'h0;
    // Clock stands low between bursts; high lasts h cycles, low h+1, h >= 2
    task automatic burst(input int i, input int n, input int h);
        repeat (n)
        begin
            @(posedge aclk) pin[i] <= 1'h1;
            repeat (h) @(posedge aclk);
            pin[i] <= 1'h0;
            repeat (h) @(posedge aclk);
        end
    endtask
    task automatic set_gate(input int i, input logic v);
        @(posedge aclk) gate[i] <= v;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_general_timers.sv ----
// Self-checking bench for the general timer block
`default_nettype none
module tb_general_timers
    import gtimer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CT [3] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_CTRL_C};
    localparam logic [7:0] CN [3] = '{OFS_COUNT_A, OFS_COUNT_B, OFS_COUNT_C};
    localparam logic [7:0] PE [3] =
        '{OFS_PERIOD_A, OFS_PERIOD_B, OFS_PERIOD_C};
    localparam logic [15:0] MK [3] =
        '{CTRL_MASK_A, CTRL_MASK_B, CTRL_MASK_C};
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, idle = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, adc;
    logic [1:0] bresp, rresp;
    logic [2:0] pin, gate, ev;
    logic [15:0] lfsr = 16'h003C;
    int err_total = 0, tests_run = 0, cyc = 0;
    int evn [3] = '{0, 0, 0};
    // Design and the pin-side model
    general_timers u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .idle_mode(idle), .ext_clock_pin_a(pin[0]),
        .ext_clock_pin_b(pin[1]), .ext_clock_pin_c(pin[2]),
        .gate_pin_a(gate[0]), .gate_pin_b(gate[1]), .gate_pin_c(gate[2]),
        .event_a(ev[0]), .event_b(ev[1]), .event_c(ev[2]),
        .adc_trigger(adc));
    gtimer_pins u_pins (.aclk(aclk), .pin(pin), .gate(gate));
    always #5 aclk = ~aclk;
    // Event tally and hang guard
    always @(posedge aclk)
    begin
        for (int i = 0; i < 3; i++)
            evn[i] <= evn[i] + int'(ev[i] === 1'h1);
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_total++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Cycles between matches: ratio times period plus one
    function automatic int gap(input logic [1:0] c, input int p);
        return (c == 2'h0 ? 1 : c == 2'h1 ? 8 : c == 2'h2 ? 64 : 256) * (p + 1);
    endfunction
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t response %h expected %h", $time, g, e);
        end
    endtask
    // Bus cycles: request held until each channel is taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk_resp(bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rready <= 1'h0;
        d = rdata;
        r = rresp;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk_resp(r, RESP_OKAY);
        chk_val(d, e);
    endtask
    // Two reads three cycles apart; count change between them
    task automatic drift(input int i, input logic [31:0] e);
        logic [31:0] a, b;
        logic [1:0] r;
        rd(CN[i], a, r);
        rd(CN[i], b, r);
        chk_val(b - a, e);
    endtask
    task automatic gap_meas(input int i, output int g);
        g = 0;
        while (ev[i] !== 1'h1)
            @(posedge aclk);
        do
        begin
            @(posedge aclk);
            g++;
        end while (ev[i] !== 1'h1);
    endtask
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        int g, p;
        logic [31:0] d;
        logic [1:0] r;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 3; i++)
        begin
            rdc(CT[i], 32'h0);
            rdc(CN[i], 32'h0);
            rdc(PE[i], 32'h0000FFFF);
            wr(CT[i], 16'hFFFF);
            rdc(CT[i], {16'h0000, MK[i]});
            wr(CT[i], 16'h0000);
        end
        wr(8'h24, 16'h1234, RESP_SLVERR);
        rd(8'h24, d, r);
        chk_resp(r, RESP_SLVERR);
        chk_val(d, 32'h0);
        // Every prescale code on every timer, random short periods
        for (int i = 0; i < 3; i++)
            for (int c = 0; c < 4; c++)
            begin
                lfsr = nxt(lfsr);
                p = lfsr[1:0] + 1;
                wr(PE[i], p[15:0]);
                wr(CN[i], 16'h0000);
                wr(CT[i], 16'h8000 | 16'(c << 4));
                gap_meas(i, g);
                chk_val(g, gap(c[1:0], p));
                wr(CT[i], 16'h0000);
            end
        // Stopped, idle with and without the halt bit
        for (int i = 0; i < 3; i++)
        begin
            wr(PE[i], 16'hFFFF);
            wr(CT[i], 16'h2000);
            drift(i, 0);
            idle <= 1'h1;
            wr(CT[i], 16'hA000);
            drift(i, 0);
            wr(CT[i], 16'h8000);
            drift(i, 3);
            idle <= 1'h0;
            wr(CT[i], 16'hA000);
            drift(i, 3);
            wr(CT[i], 16'h0000);
        end
        // Gated accumulation, then external edges with gate ignored
        for (int i = 0; i < 3; i++)
        begin
            lfsr = nxt(lfsr);
            p = lfsr[3:0] + 2;
            g = evn[i];
            wr(CN[i], 16'h0000);
            wr(CT[i], 16'h8040);
            drift(i, 0);
            u_pins.set_gate(i, 1'h1);
            repeat (p - 1) @(posedge aclk); // Gate high for p cycles
            u_pins.set_gate(i, 1'h0);
            repeat (6) @(posedge aclk);
            rdc(CN[i], p);
            chk_val(evn[i] - g, (i == 0) ? 1 : 0);
            for (int s = 0; s < 2; s++)
            begin
                wr(CN[i], 16'h0000);
                wr(CT[i], 16'h8042 | 16'(s << 2));
                u_pins.burst(i, p, 2 + s);
                repeat (8) @(posedge aclk);
                rdc(CN[i], p);
            end
            wr(CT[i], 16'h0000);
        end
        // Paired timers: carry, third control ignored, wide match
        wr(CT[1], 16'h0008);
        wr(CT[2], 16'h8000);
        wr(CN[2], 16'h0000);
        wr(CN[1], 16'hFFFE);
        wr(CT[1], 16'h8008);
        wr(CT[1], 16'h0008);
        rdc(CN[2], 32'h1);
        wr(CN[2], 16'h0000);
        wr(CN[1], 16'hFFF0);
        wr(PE[2], 16'h0001);
        wr(PE[1], 16'h0002);
        g = evn[1];
        p = evn[2];
        wr(CT[1], 16'h8008);
        repeat (40) @(posedge aclk);
        wr(CT[1], 16'h0008);
        chk_val(evn[2] - p, 1);
        chk_val(evn[1] - g, 0);
        rdc(CN[2], 32'h0);
        wr(CT[1], 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire
